// ===== hdl/rcu_consts.svh
// Constants of the radio control unit: offsets, fields, reset values and timing.
// What this block does
// - Five timed control outputs are provided for an external front-end module or power amplifier.
// - Timed output edges move in steps of one microsecond, counted by ticks from the radio clock.
// - The five outputs reach a pin when that pin selects function id 55 to 59.
// - Edges sit at programmed offsets after the rise and fall of the transmit or receive enable.
// - The unit holds the radio timing settings and takes direct strobes from the link-layer MAC.
// - The diagnostic interrupt is fed by programmable sources from the MAC and from the radio.
// - Four identical selectors, split over two registers, each have a word and a bit choice.
// - Word choice 0 or 1 picks the MAC diagnostic bit named by the bit choice; 2 or 3 picks radio.
// - On the radio side bit choice 7 is transmit, 6 receive, 5 down to 0 timed outputs 26 to 21.
// - Timed outputs 21 to 26 also trigger radio events and are visible as diagnostic sources.
// - Registers are 16 bits wide, one per aligned word, reached over the peripheral bus.
`ifndef RCU_CONSTS_SVH
`define RCU_CONSTS_SVH

`define RCU_CLK_PERIOD_NS   4
`define RCU_TICK_NS         1000
`define RCU_TICK_CYCLES     (`RCU_TICK_NS / `RCU_CLK_PERIOD_NS)

`define RCU_NUM_EXT         5
`define RCU_NUM_INT         6
`define RCU_NUM_CH          11
`define RCU_DLY_W           8
`define RCU_PID_FIRST       6'h37
`define RCU_PID_LAST        6'h3B

`define RCU_ADDR_W          12
`define RCU_OFS_CTRL        12'h000
`define RCU_OFS_STATUS      12'h004
`define RCU_OFS_MASK        12'h008
`define RCU_OFS_SEL_LOW     12'h00C
`define RCU_OFS_SEL_HIGH    12'h010
`define RCU_OFS_LIVE        12'h014
`define RCU_OFS_CHAN        12'h040
`define RCU_CHAN_SHIFT      3

`define RCU_CTRL_EN_BIT     0
`define RCU_CTRL_RST        1'h0
`define RCU_STAT_W          3
`define RCU_STAT_DIAG       0
`define RCU_STAT_START      1
`define RCU_STAT_END        2
`define RCU_STAT_RST        3'h0
`define RCU_SEL_BSEL_LSB    0
`define RCU_SEL_WSEL_LSB    4
`define RCU_SEL_STRIDE      8
`define RCU_CH_SRC_BIT      8
`define RCU_CH_EN_BIT       9

`define RCU_HSIZE_WORD      3'h2
`define RCU_HTRANS_NSEQ_BIT 1

`endif

// ===== hdl/rcu_pkg.sv
// Types shared by the radio control unit modules.
package rcu_pkg;
  `include "rcu_consts.svh"

  // Bit 1 of the state code is the channel output itself.
  typedef enum logic [1:0] {
    RCU_IDLE     = 2'b00,
    RCU_WAIT_ON  = 2'b01,
    RCU_ACTIVE   = 2'b10,
    RCU_WAIT_OFF = 2'b11
  } rcu_chan_state_t;

  typedef struct packed {
    logic                  en;
    logic                  src_rx;
    logic [`RCU_DLY_W-1:0] rise_dly;
    logic [`RCU_DLY_W-1:0] fall_dly;
  } rcu_chan_cfg_t;

  typedef struct packed {
    logic [1:0] wsel;
    logic [2:0] bsel;
  } rcu_sel_t;
endpackage : rcu_pkg

// ===== hdl/rcu_timed_chan.sv
// One timed control output channel with edge delays counted in microsecond ticks.
`timescale 1ns/1ps
module rcu_timed_chan
  import rcu_pkg::*;
(
  input  wire logic          clk,       // Radio clock.
  input  wire logic          rst_n,     // Synchronised reset, active low.
  input  wire logic          us_tick,   // One-cycle pulse each microsecond.
  input  wire logic          start,     // Rising edge of the chosen strobe.
  input  wire logic          stop,      // Falling edge of the chosen strobe.
  input  wire rcu_chan_cfg_t cfg,       // Channel settings.
  output logic               out_level  // Timed output, straight from a flop.
);

  rcu_chan_state_t       state;
  logic [`RCU_DLY_W-1:0] count;

  // Delays of zero act on the strobe edge itself; others run whole ticks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RCU_IDLE;
      count <= '0;
    end else if (!cfg.en) begin
      state <= RCU_IDLE;
      count <= '0;
    end else begin
      case (state)
        RCU_IDLE: begin
          if (start) begin
            count <= cfg.rise_dly;
            state <= (cfg.rise_dly == '0) ? RCU_ACTIVE : RCU_WAIT_ON;
          end
        end
        RCU_WAIT_ON: begin
          if (stop) begin
            state <= RCU_IDLE;
          end else if (us_tick) begin
            if (count == `RCU_DLY_W'(1)) begin
              state <= RCU_ACTIVE;
            end
            count <= count - `RCU_DLY_W'(1);
          end
        end
        RCU_ACTIVE: begin
          if (stop) begin
            count <= cfg.fall_dly;
            state <= (cfg.fall_dly == '0) ? RCU_IDLE : RCU_WAIT_OFF;
          end
        end
        RCU_WAIT_OFF: begin
          if (us_tick) begin
            if (count == `RCU_DLY_W'(1)) begin
              state <= RCU_IDLE;
            end
            count <= count - `RCU_DLY_W'(1);
          end
        end
        default: begin
          state <= RCU_IDLE;
        end
      endcase
    end
  end

  assign out_level = state[1];

endmodule : rcu_timed_chan

// ===== hdl/rcu_top.sv
// Radio control unit: timed outputs, diagnostic interrupt selection, AHB-Lite registers.
`timescale 1ns/1ps
module rcu_top
  import rcu_pkg::*;
#(
  parameter int TICK_CYCLES = `RCU_TICK_CYCLES  // Clock cycles in one microsecond.
)
(
  input  wire logic        ref_clk,          // Radio clock, 250 MHz.
  input  wire logic        rst_n,            // Asynchronous reset, active low.
  input  wire logic        hsel,             // AHB slave select.
  input  wire logic [31:0] haddr,            // AHB address.
  input  wire logic [1:0]  htrans,           // AHB transfer type.
  input  wire logic        hwrite,           // AHB write flag.
  input  wire logic [2:0]  hsize,            // AHB transfer size.
  input  wire logic [31:0] hwdata,           // AHB write data.
  input  wire logic        hready,           // AHB bus ready.
  output logic             hreadyout,        // AHB slave ready.
  output logic             hresp,            // AHB response, always OKAY.
  output logic [31:0]      hrdata,           // AHB read data.
  input  wire logic        tx_en,            // MAC transmit enable strobe.
  input  wire logic        rx_en,            // MAC receive enable strobe.
  input  wire logic [7:0]  mac_diagnostic_bit, // MAC diagnostic bus.
  input  wire logic [5:0]  pin_function_id,  // Function chosen for the output pin.
  output logic             pin_fn_out,       // Level driven to that pin.
  output logic [4:0]       timed_ext,        // Timed outputs for the front end.
  output logic [5:0]       timed_int,        // Timed outputs first to last.
  output logic             radio_diagnostic_interrupt, // OR of selected sources.
  output logic             irq               // Masked sticky event interrupt.
);

  localparam int NCH = `RCU_NUM_CH;
  localparam int TW  = $clog2(TICK_CYCLES + 1);

  // A tick period below one cycle cannot be produced by the divider.
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // Reset release through two flops; the rest of the design uses the copy.
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Register state.
  logic                   ctrl_en;
  logic [`RCU_STAT_W-1:0] status;
  logic [`RCU_STAT_W-1:0] mask;
  rcu_sel_t               sel [4];
  rcu_chan_cfg_t          chan_cfg [NCH];

  // Bus data-phase bookkeeping.
  logic                   wr_pend;
  logic                   wr_full;
  logic                   rd_pend;
  logic [`RCU_ADDR_W-1:0] dp_addr;

  // Strobe history for edge detection; strobes share this clock.
  logic tx_q;
  logic rx_q;
  logic diag_q;

  logic [NCH-1:0] timed;
  logic [TW-1:0]  tick_cnt;
  logic           us_tick;

  // Selector decode shared by all four selectors.
  function automatic logic pick_src(input rcu_sel_t s, input logic [7:0] mac,
                                    input logic [7:0] radio);
    if (s.wsel[1] == 1'b0) begin
      pick_src = mac[s.bsel];
    end else begin
      pick_src = radio[s.bsel];
    end
  endfunction : pick_src

  // Channel index of a channel-region address, or NCH when outside it.
  function automatic int chan_index(input logic [`RCU_ADDR_W-1:0] a);
    logic [`RCU_ADDR_W-1:0] rel;
    rel = a - `RCU_OFS_CHAN;
    if (a < `RCU_OFS_CHAN || int'(rel >> `RCU_CHAN_SHIFT) >= NCH) begin
      chan_index = NCH;
    end else begin
      chan_index = int'(rel >> `RCU_CHAN_SHIFT);
    end
  endfunction : chan_index

  // Microsecond tick divider; it runs only while the unit is enabled.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_cnt <= '0;
    end else if (!ctrl_en || tick_cnt == TW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TW'(1);
    end
  end
  assign us_tick = ctrl_en && (tick_cnt == TW'(TICK_CYCLES - 1));

  // Previous strobe levels for the edge pulses below.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_q   <= 1'b0;
      rx_q   <= 1'b0;
      diag_q <= 1'b0;
    end else begin
      tx_q   <= tx_en;
      rx_q   <= rx_en;
      diag_q <= radio_diagnostic_interrupt;
    end
  end

  logic tx_rise;
  logic tx_fall;
  logic rx_rise;
  logic rx_fall;
  assign tx_rise = tx_en && !tx_q;
  assign tx_fall = !tx_en && tx_q;
  assign rx_rise = rx_en && !rx_q;
  assign rx_fall = !rx_en && rx_q;

  // Channels 0 to 4 face the front end; 5 to 10 are the radio-internal set.
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    rcu_timed_chan u_chan (
      .clk       (ref_clk),
      .rst_n     (rst_sync_n),
      .us_tick   (us_tick),
      .start     (ctrl_en && (chan_cfg[c].src_rx ? rx_rise : tx_rise)),
      .stop      (ctrl_en && (chan_cfg[c].src_rx ? rx_fall : tx_fall)),
      .cfg       (chan_cfg[c]),
      .out_level (timed[c])
    );
  end

  assign timed_ext = timed[`RCU_NUM_EXT-1:0];
  assign timed_int = timed[NCH-1:`RCU_NUM_EXT];

  // Pin function mux; ids outside the window leave the pin low.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_fn_out <= 1'b0;
    end else if (pin_function_id >= `RCU_PID_FIRST && pin_function_id <= `RCU_PID_LAST) begin
      pin_fn_out <= timed[3'(pin_function_id - `RCU_PID_FIRST)];
    end else begin
      pin_fn_out <= 1'b0;
    end
  end

  // Four selectors OR-ed into the diagnostic line, held in a flop.
  logic [7:0] radio_vec;
  logic [3:0] sel_hit;
  assign radio_vec = {tx_en, rx_en, timed[NCH-1:`RCU_NUM_EXT]};
  for (genvar s = 0; s < 4; s++) begin : g_sel
    assign sel_hit[s] = pick_src(sel[s], mac_diagnostic_bit, radio_vec);
  end
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      radio_diagnostic_interrupt <= 1'b0;
    end else begin
      radio_diagnostic_interrupt <= |sel_hit;
    end
  end

  // AHB address phase; reads take one wait state so hrdata comes from a flop.
  logic addr_ok;
  assign addr_ok = hsel && htrans[`RCU_HTRANS_NSEQ_BIT] && hready;
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend <= 1'b0;
      wr_full <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= '0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_full <= hsize == `RCU_HSIZE_WORD;
      rd_pend <= addr_ok && !hwrite;
      if (addr_ok) begin
        dp_addr <= haddr[`RCU_ADDR_W-1:0];
      end
    end
  end
  assign hreadyout = !rd_pend;
  assign hresp     = 1'b0;

  // Narrow writes are dropped, which keeps the 16-bit registers whole.
  logic wr_go;
  int   wr_ch;
  assign wr_go = wr_pend && wr_full;
  assign wr_ch = chan_index(dp_addr);

  // Control, mask and selector registers.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_en <= `RCU_CTRL_RST;
      mask    <= `RCU_STAT_RST;
      for (int i = 0; i < 4; i++) begin
        sel[i] <= '0;
      end
    end else if (wr_go) begin
      if (dp_addr == `RCU_OFS_CTRL) begin
        ctrl_en <= hwdata[`RCU_CTRL_EN_BIT];
      end else if (dp_addr == `RCU_OFS_MASK) begin
        mask <= hwdata[`RCU_STAT_W-1:0];
      end else if (dp_addr == `RCU_OFS_SEL_LOW || dp_addr == `RCU_OFS_SEL_HIGH) begin
        for (int i = 0; i < 2; i++) begin
          sel[(dp_addr == `RCU_OFS_SEL_HIGH ? 2 : 0) + i] <= '{
            wsel: hwdata[i*`RCU_SEL_STRIDE+`RCU_SEL_WSEL_LSB +: 2],
            bsel: hwdata[i*`RCU_SEL_STRIDE+`RCU_SEL_BSEL_LSB +: 3]};
        end
      end
    end
  end

  // Channel settings: low word rise delay, source and enable; high word fall delay.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < NCH; i++) begin
        chan_cfg[i] <= '0;
      end
    end else if (wr_go && wr_ch < NCH) begin
      if (dp_addr[2] == 1'b0) begin
        chan_cfg[wr_ch].rise_dly <= hwdata[`RCU_DLY_W-1:0];
        chan_cfg[wr_ch].src_rx   <= hwdata[`RCU_CH_SRC_BIT];
        chan_cfg[wr_ch].en       <= hwdata[`RCU_CH_EN_BIT];
      end else begin
        chan_cfg[wr_ch].fall_dly <= hwdata[`RCU_DLY_W-1:0];
      end
    end
  end

  // Sticky events; a new event in the clearing cycle wins over the clear.
  logic [`RCU_STAT_W-1:0] ev;
  logic [`RCU_STAT_W-1:0] clr;
  assign ev[`RCU_STAT_DIAG]  = radio_diagnostic_interrupt && !diag_q;
  assign ev[`RCU_STAT_START] = tx_rise || rx_rise;
  assign ev[`RCU_STAT_END]   = tx_fall || rx_fall;
  assign clr = (wr_go && dp_addr == `RCU_OFS_STATUS) ? hwdata[`RCU_STAT_W-1:0] : '0;
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status <= `RCU_STAT_RST;
    end else begin
      status <= (status & ~clr) | ev;
    end
  end

  // Level interrupt from a flop, high while an unmasked event is held.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Read mux; unmapped addresses read as zero with an OKAY answer.
  logic [31:0] rd_val;
  int          rd_ch;
  always_comb begin
    rd_ch  = chan_index(dp_addr);
    rd_val = 32'h0000_0000;
    if (dp_addr == `RCU_OFS_CTRL) begin
      rd_val[`RCU_CTRL_EN_BIT] = ctrl_en;
    end else if (dp_addr == `RCU_OFS_STATUS) begin
      rd_val[`RCU_STAT_W-1:0] = status;
    end else if (dp_addr == `RCU_OFS_MASK) begin
      rd_val[`RCU_STAT_W-1:0] = mask;
    end else if (dp_addr == `RCU_OFS_SEL_LOW || dp_addr == `RCU_OFS_SEL_HIGH) begin
      for (int i = 0; i < 2; i++) begin
        rd_val[i*`RCU_SEL_STRIDE+`RCU_SEL_WSEL_LSB +: 2] =
          sel[(dp_addr == `RCU_OFS_SEL_HIGH ? 2 : 0) + i].wsel;
        rd_val[i*`RCU_SEL_STRIDE+`RCU_SEL_BSEL_LSB +: 3] =
          sel[(dp_addr == `RCU_OFS_SEL_HIGH ? 2 : 0) + i].bsel;
      end
    end else if (dp_addr == `RCU_OFS_LIVE) begin
      rd_val[13:0] = {tx_en, rx_en, radio_diagnostic_interrupt, timed};
    end else if (rd_ch < NCH) begin
      if (dp_addr[2] == 1'b0) begin
        rd_val[`RCU_DLY_W-1:0]   = chan_cfg[rd_ch].rise_dly;
        rd_val[`RCU_CH_SRC_BIT]  = chan_cfg[rd_ch].src_rx;
        rd_val[`RCU_CH_EN_BIT]   = chan_cfg[rd_ch].en;
      end else begin
        rd_val[`RCU_DLY_W-1:0]   = chan_cfg[rd_ch].fall_dly;
      end
    end
  end

  // Read data is captured during the wait state and held afterwards.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= rd_val;
    end
  end

endmodule : rcu_top

// ===== verif/rcu_props.sv
// Concurrent checks on the ports of the radio control unit.
`timescale 1ns/1ps
module rcu_props #(
  parameter int TICK_CYCLES = 250  // Cycles per microsecond.
)(
  input wire logic        ref_clk,         // Radio clock.
  input wire logic        rst_n,           // Reset, active low.
  input wire logic        hsel,            // Slave select.
  input wire logic [1:0]  htrans,          // Transfer type.
  input wire logic        hwrite,          // Write flag.
  input wire logic        hready,          // Bus ready.
  input wire logic        hreadyout,       // Slave ready.
  input wire logic        hresp,           // Response.
  input wire logic [31:0] hrdata,          // Read data.
  input wire logic [5:0]  pin_function_id, // Pin function.
  input wire logic        pin_fn_out,      // Pin level.
  input wire logic [4:0]  timed_ext        // Timed outputs.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");

  property p_rd_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");

  property p_wr_nowait; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");

  property p_wait_cause; !hreadyout |-> $past(hsel && htrans[1] && hready && !hwrite); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stray wait");

  // Read data may only move at the edge that ends a read wait cycle.
  property p_data_hold; !$stable(hrdata) |-> $past(hreadyout) == 1'b0; endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved");

  property p_upper_zero; $past(hreadyout) == 1'b0 |-> hrdata[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

  property p_pin_sel;
    pin_function_id >= 6'h37 && pin_function_id <= 6'h3B
      |=> pin_fn_out == $past(timed_ext[pin_function_id - 6'h37]);
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("pin level wrong");

  property p_pin_off; !(pin_function_id >= 6'h37 && pin_function_id <= 6'h3B) |=> !pin_fn_out;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven");
endmodule : rcu_props

bind rcu_top rcu_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pin_function_id(pin_function_id), .pin_fn_out(pin_fn_out), .timed_ext(timed_ext));

// ===== verif/rcu_mac_model.sv
// Behavioural link-layer MAC raising one enable strobe per request.
`timescale 1ns/1ps
module rcu_mac_model (
  input  wire logic       clk,    // Radio clock.
  input  wire logic       rst_n,  // Reset, active low.
  input  wire logic       req,    // Start a strobe.
  input  wire logic       rx_sel, // High for receive, low for transmit.
  input  wire logic [7:0] len,    // Strobe length in cycles.
  output logic            tx_en,  // Transmit enable.
  output logic            rx_en   // Receive enable.
);
  logic [7:0] left;

  // Clean pulses on the shared clock, since the unit has no strobe synchroniser.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left  <= 8'h00;
      tx_en <= 1'b0;
      rx_en <= 1'b0;
    end else if (req) begin
      left  <= len;
      tx_en <= !rx_sel;
      rx_en <= rx_sel;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      left  <= 8'h00;
      tx_en <= 1'b0;
      rx_en <= 1'b0;
    end
  end
endmodule : rcu_mac_model

// ===== verif/tb.sv
// Self-checking bench for the radio control unit.
`timescale 1ns/1ps
`include "rcu_consts.svh"
module tb;
  localparam int T = 4;
  localparam logic [2:0] W = 3'h2;
  logic        ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, req, req_rx;
  logic        tx_en, rx_en, pin_fn_out, irq_diag, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  mac_bits, req_len;
  logic [5:0]  pin_id, timed_int;
  logic [4:0]  timed_ext;
  logic [10:0] outs;
  int          fail_count, check_count;
  // Registers whose reset value is checked first, with one unmapped slot last.
  logic [11:0] ra [5] = '{`RCU_OFS_CTRL, `RCU_OFS_STATUS, `RCU_OFS_MASK,
                          `RCU_OFS_SEL_LOW, 12'h020};

  assign hready = hreadyout;
  assign outs   = {timed_int, timed_ext};

  rcu_top #(.TICK_CYCLES(T)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_en(tx_en), .rx_en(rx_en),
    .mac_diagnostic_bit(mac_bits), .pin_function_id(pin_id), .pin_fn_out(pin_fn_out),
    .timed_ext(timed_ext), .timed_int(timed_int),
    .radio_diagnostic_interrupt(irq_diag), .irq(irq));

  rcu_mac_model mac (.clk(ref_clk), .rst_n(rst_n), .req(req), .rx_sel(req_rx),
    .len(req_len), .tx_en(tx_en), .rx_en(rx_en));

  // Free-running radio clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Ready is sampled at the negedge so the value seen is the one held at the rising edge.
  task automatic rdy(output logic [31:0] d);
    logic r;
    for (int i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      r = hreadyout;
      d = hrdata;
      @(posedge ref_clk);
      if (r === 1'b1) break;
    end
  endtask : rdy

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [2:0] sz);
    logic [31:0] x;
    hsel <= 1'b1; haddr <= {20'h00000, a}; htrans <= 2'h2; hwrite <= 1'b1; hsize <= sz;
    rdy(x);
    htrans <= 2'h0; hwdata <= d;
    rdy(x);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    hsel <= 1'b1; haddr <= {20'h00000, a}; htrans <= 2'h2; hwrite <= 1'b0; hsize <= W;
    rdy(d);
    htrans <= 2'h0;
    rdy(d);
  endtask : rd

  task automatic go(input logic rx, input logic [7:0] n);
    req <= 1'b1; req_rx <= rx; req_len <= n;
    @(posedge ref_clk);
    req <= 1'b0;
    @(negedge ref_clk);
  endtask : go

  task automatic cnt(input int c, input logic lv, output int n);
    n = 0;
    while (outs[c] !== lv && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : cnt

  function automatic logic in_win(input int n, input int d);
    return (d == 0) ? (n == 1) : (n >= (d - 1) * T + 1 && n <= d * T + 1);
  endfunction : in_win

  task automatic sel(input logic [31:0] s);
    wr(`RCU_OFS_SEL_LOW, {16'h0000, s[15:0]}, W);
    wr(`RCU_OFS_SEL_HIGH, {16'h0000, s[31:16]}, W);
  endtask : sel

  // Main sequence: bus basics, selectors, radio sources, timed channels, events.
  initial begin
    logic [31:0] d, s;
    logic [11:0] a;
    int          n, r, f;
    rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = W;
    hwdata = '0; req = 1'b0; req_rx = 1'b0; req_len = 8'h00; mac_bits = 8'h00;
    pin_id = 6'h00; fail_count = 0; check_count = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    foreach (ra[i]) begin
      rd(ra[i], d); chk("reset", d, 32'h0);
    end
    wr(`RCU_OFS_CTRL, 32'h1, 3'h0);
    rd(`RCU_OFS_CTRL, d); chk("byte_wr", d, 32'h0);
    wr(12'h020, 32'h1, W);
    rd(12'h020, d); chk("unmapped", d, 32'h0);
    wr(`RCU_OFS_CTRL, 32'h1, W);
    rd(`RCU_OFS_CTRL, d); chk("ctrl", d, 32'h1);
    // Every selector, word choice and bit choice; the others point at an idle source.
    for (int k = 0; k < 4; k++) for (int w = 0; w < 4; w++) for (int b = 0; b < 8; b++) begin
      s = 32'h20202020;
      s[8*k+:8] = {2'b00, 2'(w), 1'b0, 3'(b)};
      sel(s);
      mac_bits <= 8'h01 << b;
      repeat (3) @(negedge ref_clk);
      chk("sel_hit", irq_diag, w < 2);
      @(posedge ref_clk);
      mac_bits <= ~(8'h01 << b);
      repeat (3) @(negedge ref_clk);
      chk("sel_miss", irq_diag, 32'h0);
      @(posedge ref_clk);
    end
    mac_bits <= 8'h00;
    for (int i = 0; i < 2; i++) begin
      sel(i ? 32'h20202036 : 32'h20202027);
      go(1'(i), 8'd20);
      repeat (3) @(negedge ref_clk);
      chk("radio_src", irq_diag, 32'h1);
      repeat (20) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    sel(32'h20202020);
    wr(`RCU_OFS_STATUS, 32'h7, W);
    // Each channel alone, with its own delays; the first internal one feeds the interrupt.
    for (int c = 0; c < 11; c++) begin
      r = c % 4;
      f = 1 + c % 3;
      a = `RCU_OFS_CHAN + 12'(8 * c);
      pin_id <= (c < 5) ? 6'(55 + c) : 6'h00;
      wr(a + 12'h4, 32'(f), W);
      wr(a, {22'h0, 1'b1, 1'(c % 2), 8'(r)}, W);
      go(1'(c % 2), 8'd40);
      cnt(c, 1'b1, n); chk("rise", in_win(n, r), 32'h1);
      @(negedge ref_clk);
      chk("pin", pin_fn_out, c < 5);
      chk("diag", irq_diag, c == 5);
      while (tx_en === 1'b1 || rx_en === 1'b1) @(negedge ref_clk);
      cnt(c, 1'b0, n); chk("fall", in_win(n, f), 32'h1);
      @(posedge ref_clk);
      wr(a, 32'h0, W);
    end
    rd(`RCU_OFS_STATUS, d); chk("status", d, 32'h7);
    chk("irq_masked", irq, 32'h0);
    wr(`RCU_OFS_MASK, 32'h4, W);
    repeat (2) @(negedge ref_clk);
    chk("irq_on", irq, 32'h1);
    @(posedge ref_clk);
    wr(`RCU_OFS_STATUS, 32'h4, W);
    repeat (2) @(negedge ref_clk);
    chk("irq_off", irq, 32'h0);
    @(posedge ref_clk);
    rd(`RCU_OFS_STATUS, d); chk("status_w1c", d, 32'h3);
    end_sim();
  end

  // Cuts a hang short well beyond the expected few thousand cycles.
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule : tb
